/* include/tfc_pkg.sv */
// ----------------------------------------------------------------------------
// Timer flip-flop output control: shared constants and types
// ----------------------------------------------------------------------------
package tfc_pkg;

  // --------------------------------------------------------------------------
  // Geometry
  // --------------------------------------------------------------------------
  localparam int NUM_CH_DEF   = 4;
  localparam int CNT_W        = 16;
  localparam int TICK_DIV_DEF = 8;
  localparam int WB_AW        = 8;

  // --------------------------------------------------------------------------
  // Word offsets (byte address = index * 4); bit 7 of the byte address
  // selects the global bank, bits 6:5 pick the channel
  // --------------------------------------------------------------------------
  localparam logic [2:0] REG_FFCR     = 3'h0;
  localparam logic [2:0] REG_CTRL     = 3'h1;
  localparam logic [2:0] REG_CMP0     = 3'h2;
  localparam logic [2:0] REG_CMP1     = 3'h3;
  localparam logic [2:0] REG_CAP0     = 3'h4;
  localparam logic [2:0] REG_CAP1     = 3'h5;
  localparam logic [2:0] REG_STATE    = 3'h6;
  localparam logic [2:0] REG_IRQ_STAT = 3'h0;
  localparam logic [2:0] REG_IRQ_MASK = 3'h1;
  localparam int ADR_BANK_BIT   = 7;
  localparam int ADR_CH_HI      = 6;
  localparam int ADR_CH_LO      = 5;
  localparam int ADR_REG_HI     = 4;
  localparam int ADR_REG_LO     = 2;

  // --------------------------------------------------------------------------
  // Control field codes and bit positions
  // --------------------------------------------------------------------------
  localparam logic [1:0] CTL_INVERT = 2'h0;
  localparam logic [1:0] CTL_SET    = 2'h1;
  localparam logic [1:0] CTL_CLEAR  = 2'h2;
  localparam logic [1:0] CTL_KEEP   = 2'h3;
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_IVAL_BIT = 1;
  localparam int CTRL_SWC0_BIT = 2;
  localparam int CTRL_SWC1_BIT = 3;
  localparam int STATE_FA_BIT  = 16;
  localparam int STATE_FB_BIT  = 17;
  localparam logic [3:0] EN_RESET = 4'h0;

  // Flop control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] flop_b_ctl;
    logic       capture1_toggle_en;
    logic       capture0_toggle_en;
    logic       match1_toggle_en;
    logic       match0_toggle_en;
    logic [1:0] flop_a_ctl;
  } tfc_ffcr_s;

endpackage

/* hw/tfc_timer_flop.sv */
// Overview of operation
// - A write to flop_a_ctl toggles flop A on 00, sets it on 01, clears it on 10, keeps on 11.
// - A write to flop_b_ctl toggles flop B on 00, sets it on 01, clears it on 10, keeps on 11.
// - Both two-bit control fields always read back as 11.
// - With match0_toggle_en set, flop A inverts whenever the counter equals compare_reg0.
// - With match1_toggle_en set, flop A inverts whenever the counter equals compare_reg1.
// - With capture0_toggle_en set, flop A inverts whenever capture_reg0 is loaded.
// - With capture1_toggle_en set, flop A inverts whenever capture_reg1 is loaded.
// - In interval mode compare1_interrupt fires at a fixed period set by 16-bit compare_reg1.
// - While running in interval mode the compare1_interrupt repeats every period.
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps

module tfc_timer_flop
  import tfc_pkg::*;
#(
  parameter int NUM_CH   = NUM_CH_DEF,
  parameter int TICK_DIV = TICK_DIV_DEF
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [WB_AW-1:0]    wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Hardware capture strobes, one cycle each
  input  wire logic [NUM_CH-1:0]   cap0_trig_i,
  input  wire logic [NUM_CH-1:0]   cap1_trig_i,
  // Timer flip-flop outputs and interrupt
  output logic      [NUM_CH-1:0]   timer_flop_a_o,
  output logic      [NUM_CH-1:0]   timer_flop_b_o,
  output logic                     irq_o
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  localparam int DIV_W = $clog2(TICK_DIV + 1);
  localparam int EV_W  = 2 * NUM_CH;

  if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 4");
  end
  if (TICK_DIV < 1) begin : g_bad_div
    $error("TICK_DIV must be at least 1");
  end
  // Status and mask are written through byte lane 0 alone
  if (EV_W > 8) begin : g_bad_ev
    $error("Event bits do not fit the status byte");
  end
  // Bank bit and channel field must lie inside the address
  if (WB_AW <= ADR_BANK_BIT) begin : g_bad_aw
    $error("WB_AW too narrow for the register map");
  end
  // Readback packs counter, compares and captures into the low half word
  if (CNT_W != 16) begin : g_bad_cnt
    $error("CNT_W must be 16 for the register layout");
  end

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic            ack_reg;
  logic [31:0]     dat_reg;
  wire             acc_w    = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire             wr_w     = acc_w & wb_we_i;
  wire             bank_w   = wb_adr_i[ADR_BANK_BIT];
  wire [1:0]       ch_w     = wb_adr_i[ADR_CH_HI:ADR_CH_LO];
  wire [2:0]       idx_w    = wb_adr_i[ADR_REG_HI:ADR_REG_LO];
  wire             g_wr_w   = wr_w & bank_w;
  wire             stat_wr  = g_wr_w & (idx_w == REG_IRQ_STAT) & wb_sel_i[0];
  wire             mask_wr  = g_wr_w & (idx_w == REG_IRQ_MASK) & wb_sel_i[0];

  // --------------------------------------------------------------------------
  // Prescaler: one-cycle count enable every TICK_DIV clocks
  // --------------------------------------------------------------------------
  logic [DIV_W-1:0] div_reg;
  logic             tick_reg;
  wire              div_end = (div_reg == DIV_W'(TICK_DIV - 1));

  // Free-running divider keeps the period independent of bus traffic;
  // with TICK_DIV of 1 the tick stands high on every cycle from the second cycle after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_end ? '0 : div_reg + DIV_W'(1);
      tick_reg <= div_end;
    end
  end

  // --------------------------------------------------------------------------
  // Per-channel timer state
  // --------------------------------------------------------------------------
  logic [EV_W-1:0]  ev_w;
  logic [31:0]      rd_ch_w [NUM_CH];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cmp0_reg;
    logic [CNT_W-1:0] cmp1_reg;
    logic [CNT_W-1:0] cap0_reg;
    logic [CNT_W-1:0] cap1_reg;
    logic [3:0]       en_reg;
    logic             run_reg;
    logic             ival_reg;
    logic             fa_reg;
    logic             fb_reg;
    tfc_ffcr_s        wd;

    // Register selects for this channel
    wire ch_wr    = wr_w & ~bank_w & (ch_w == 2'(c));
    wire ffcr_wr  = ch_wr & (idx_w == REG_FFCR) & wb_sel_i[0];
    wire ctrl_wr  = ch_wr & (idx_w == REG_CTRL) & wb_sel_i[0];
    wire cmp0_wr  = ch_wr & (idx_w == REG_CMP0);
    wire cmp1_wr  = ch_wr & (idx_w == REG_CMP1);
    assign wd     = tfc_ffcr_s'(wb_dat_i[7:0]);

    // Byte-lane strobes, so a byte store updates only its byte of the compare
    wire cmp0_lo_wr = cmp0_wr & wb_sel_i[0];
    wire cmp0_hi_wr = cmp0_wr & wb_sel_i[1];
    wire cmp1_lo_wr = cmp1_wr & wb_sel_i[0];
    wire cmp1_hi_wr = cmp1_wr & wb_sel_i[1];

    // Match events taken on the counting tick; capture events on any cycle
    wire cnt_en   = tick_reg & run_reg;
    wire match0   = cnt_en & (cnt_reg == cmp0_reg);
    wire match1   = cnt_en & (cnt_reg == cmp1_reg);
    wire swc0     = ctrl_wr & wb_dat_i[CTRL_SWC0_BIT];
    wire swc1     = ctrl_wr & wb_dat_i[CTRL_SWC1_BIT];
    wire cap0_ev  = cap0_trig_i[c] | swc0;
    wire cap1_ev  = cap1_trig_i[c] | swc1;

    wire inv_m0   = match0 & en_reg[0];
    wire inv_m1   = match1 & en_reg[1];
    wire inv_c0   = cap0_ev & en_reg[2];
    wire inv_c1   = cap1_ev & en_reg[3];
    // Simultaneous triggers each invert once, so only parity counts
    wire hw_inv   = inv_m0 ^ inv_m1 ^ inv_c0 ^ inv_c1;

    wire a_set    = ffcr_wr & (wd.flop_a_ctl == CTL_SET);
    wire a_clr    = ffcr_wr & (wd.flop_a_ctl == CTL_CLEAR);
    wire a_inv    = (ffcr_wr & (wd.flop_a_ctl == CTL_INVERT)) ^ hw_inv;
    // Software force wins over a coincident hardware trigger
    wire fa_next  = a_set ? 1'b1 : (a_clr ? 1'b0 : (fa_reg ^ a_inv));
    wire b_set    = ffcr_wr & (wd.flop_b_ctl == CTL_SET);
    wire b_clr    = ffcr_wr & (wd.flop_b_ctl == CTL_CLEAR);
    wire b_inv    = ffcr_wr & (wd.flop_b_ctl == CTL_INVERT);
    wire fb_next  = b_set ? 1'b1 : (b_clr ? 1'b0 : (fb_reg ^ b_inv));

    wire restart  = ival_reg & match1;
    wire [CNT_W-1:0] cnt_next = restart ? '0 : cnt_reg + CNT_W'(1);

    // Flip-flops and control bits
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        fa_reg <= 1'b0;
        fb_reg <= 1'b0;
        en_reg <= EN_RESET;
      end else begin
        fa_reg <= fa_next;
        fb_reg <= fb_next;
        if (ffcr_wr) begin
          en_reg <= {wd.capture1_toggle_en, wd.capture0_toggle_en,
                     wd.match1_toggle_en, wd.match0_toggle_en};
        end
      end
    end

    // Run and mode bits
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        run_reg  <= 1'b0;
        ival_reg <= 1'b0;
      end else if (ctrl_wr) begin
        run_reg  <= wb_dat_i[CTRL_RUN_BIT];
        ival_reg <= wb_dat_i[CTRL_IVAL_BIT];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_reg <= '0;
      end else if (cnt_en) begin
        cnt_reg <= cnt_next;
      end
    end

    // Compare registers, byte lanes honoured
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cmp0_reg <= '1;
        cmp1_reg <= '1;
      end else begin
        if (cmp0_lo_wr) cmp0_reg[7:0]  <= wb_dat_i[7:0];
        if (cmp0_hi_wr) cmp0_reg[15:8] <= wb_dat_i[15:8];
        if (cmp1_lo_wr) cmp1_reg[7:0]  <= wb_dat_i[7:0];
        if (cmp1_hi_wr) cmp1_reg[15:8] <= wb_dat_i[15:8];
      end
    end

    // Capture registers load the live counter
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cap0_reg <= '0;
        cap1_reg <= '0;
      end else begin
        if (cap0_ev) cap0_reg <= cnt_reg;
        if (cap1_ev) cap1_reg <= cnt_reg;
      end
    end

    // Events for the interrupt status register
    assign ev_w[2*c]   = match0;
    assign ev_w[2*c+1] = match1;

    // Codes read back as keep, so a stale read written back changes no flop
    // Readback mux; control fields read as 11
    assign rd_ch_w[c] =
        (idx_w == REG_FFCR)  ? {24'h00_0000, CTL_KEEP, en_reg[3], en_reg[2],
                                en_reg[1], en_reg[0], CTL_KEEP} :
        (idx_w == REG_CTRL)  ? {30'h0000_0000, ival_reg, run_reg} :
        (idx_w == REG_CMP0)  ? {16'h0000, cmp0_reg} :
        (idx_w == REG_CMP1)  ? {16'h0000, cmp1_reg} :
        (idx_w == REG_CAP0)  ? {16'h0000, cap0_reg} :
        (idx_w == REG_CAP1)  ? {16'h0000, cap1_reg} :
        (idx_w == REG_STATE) ? {14'h0000, fb_reg, fa_reg, cnt_reg} :
                               32'h0000_0000;

    assign timer_flop_a_o[c] = fa_reg;
    assign timer_flop_b_o[c] = fb_reg;
  end

  // --------------------------------------------------------------------------
  // Interrupt status and mask
  // --------------------------------------------------------------------------
  logic [EV_W-1:0] stat_reg;
  logic [EV_W-1:0] mask_reg;
  logic            irq_reg;
  wire  [EV_W-1:0] w1c_w     = stat_wr ? wb_dat_i[EV_W-1:0] : '0;
  // New events win over a clearing write in the same cycle
  wire  [EV_W-1:0] stat_next = (stat_reg & ~w1c_w) | ev_w;
  // Level is registered from the next status, so it rises in the same cycle as the status bit
  wire             irq_next  = |(stat_next & mask_reg);

  // Sticky status, mask and registered level irq
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= '0;
      mask_reg <= '0;
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      if (mask_wr) mask_reg <= wb_dat_i[EV_W-1:0];
      irq_reg  <= irq_next;
    end
  end

  // --------------------------------------------------------------------------
  // Bus answer: one wait state, unmapped reads return zero
  // --------------------------------------------------------------------------
  // Channels NUM_CH and above are holes: writes drop, reads return zero
  wire        ch_ok  = (32'(ch_w) < NUM_CH);
  wire [31:0] rd_glb = (idx_w == REG_IRQ_STAT) ? 32'(stat_reg) :
                       (idx_w == REG_IRQ_MASK) ? 32'(mask_reg) : 32'h0000_0000;
  wire [31:0] rd_w   = bank_w ? rd_glb : (ch_ok ? rd_ch_w[ch_w] : 32'h0000_0000);

  // Ack drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= acc_w;
      if (acc_w) dat_reg <= rd_w;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o    = irq_reg;

endmodule

/* tb/tfc_timer_flop_asserts.sv */
`timescale 1ns/1ps

module tfc_timer_flop_asserts
  import tfc_pkg::*;
#(
  parameter int NUM_CH   = NUM_CH_DEF,
  parameter int TICK_DIV = TICK_DIV_DEF
) (
  // Clock, reset and register bus
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [WB_AW-1:0]  wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  // Capture strobes, flops and interrupt
  input wire logic [NUM_CH-1:0] cap0_trig_i,
  input wire logic [NUM_CH-1:0] cap1_trig_i,
  input wire logic [NUM_CH-1:0] timer_flop_a_o,
  input wire logic [NUM_CH-1:0] timer_flop_b_o,
  input wire logic              irq_o
);
  // Channel 0 flop control write taken this edge
  logic       take_wr;
  logic [3:0] en_reg;
  assign take_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00
                   && wb_sel_i[0];

  // Shadow of the trigger enables, so toggle checks know when they apply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg <= EN_RESET;
    end else if (take_wr) begin
      en_reg <= wb_dat_i[5:2];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  ctl_reads_ones_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> wb_dat_o[7:6] == 2'b11 && wb_dat_o[1:0] == 2'b11)
    else $error("control field did not read as ones");
  flop_b_set_a: assert property (
    take_wr && wb_dat_i[7:6] == CTL_SET |-> ##2 timer_flop_b_o[0])
    else $error("flop b not set");
  flop_b_invert_a: assert property (
    take_wr && wb_dat_i[7:6] == CTL_INVERT
    |-> ##2 timer_flop_b_o[0] != $past(timer_flop_b_o[0], 2))
    else $error("flop b not inverted");
  flop_b_keep_a: assert property (
    take_wr && wb_dat_i[7:6] == CTL_KEEP |-> ##2 timer_flop_b_o[0] == $past(timer_flop_b_o[0], 2))
    else $error("flop b changed on keep code");
  flop_a_clear_a: assert property (
    take_wr && wb_dat_i[5:0] == 6'h02 |-> ##2 !timer_flop_a_o[0])
    else $error("flop a not cleared");
  capture_toggle_a: assert property (
    (cap0_trig_i[0] && !cap1_trig_i[0] && en_reg == 4'h4 && !wb_cyc_i)
    ##1 (!cap0_trig_i[0] && !cap1_trig_i[0] && !wb_cyc_i)
    |-> ##1 timer_flop_a_o[0] != $past(timer_flop_a_o[0], 2))
    else $error("capture did not invert flop a");
  reset_state_a: assert property (
    $fell(rst_i) |-> !irq_o && timer_flop_a_o == '0 && timer_flop_b_o == '0)
    else $error("outputs not idle after reset");
endmodule

bind tfc_timer_flop tfc_timer_flop_asserts #(.NUM_CH(NUM_CH), .TICK_DIV(TICK_DIV)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cap0_trig_i(cap0_trig_i), .cap1_trig_i(cap1_trig_i),
  .timer_flop_a_o(timer_flop_a_o), .timer_flop_b_o(timer_flop_b_o), .irq_o(irq_o));

/* tb/timer_flipflop_output_control_bench.sv */
`timescale 1ns/1ps

module timer_flipflop_output_control_bench;
  import tfc_pkg::*;
  // Bench drive and observed outputs
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] dat   = 32'h0000_0000;
  logic [3:0]  cap0  = 4'h0;
  logic [3:0]  cap1  = 4'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        ack;
  logic        irq;
  logic [3:0]  fa;
  logic [3:0]  fb;
  int          failures = 0;
  int          samples_checked = 0;

  always #4 clk_i = ~clk_i;

  // Tick every clock so an interval is only a few cycles long
  tfc_timer_flop #(.NUM_CH(4), .TICK_DIV(1)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .cap0_trig_i(cap0), .cap1_trig_i(cap1), .timer_flop_a_o(fa), .timer_flop_b_o(fb),
    .irq_o(irq));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; a missing ack ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      failures++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, rd);
  endtask

  function automatic logic nxt(input logic f, input logic [1:0] c);
    case (c)
      CTL_INVERT: return !f;
      CTL_SET: return 1'b1;
      CTL_CLEAR: return 1'b0;
      default: return f;
    endcase
  endfunction

  task automatic t_reset();
    wb(1'b0, 8'h00, 32'h0000_0000, rd);
    check(rd, 32'h0000_00C3);
    wb(1'b0, 8'h84, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    wb(1'b0, 8'h98, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    check({24'h0, fb, fa}, 32'h0000_0000);
    $display("reset test done");
  endtask

  // Every code on both flops of every channel
  task automatic t_soft();
    logic [1:0] codes [6] = '{2'h1, 2'h0, 2'h0, 2'h3, 2'h2, 2'h3};
    logic       ea;
    for (int c = 0; c < 4; c++) begin
      ea = 1'b0;
      for (int k = 0; k < 6; k++) begin
        wr(8'(c * 32), {24'h0, codes[k], 4'h0, codes[k]});
        ea = nxt(ea, codes[k]);
        check({30'h0, fb[c], fa[c]}, {30'h0, ea, ea});
      end
    end
    $display("software control test done");
  endtask

  task automatic pulse(input logic second);
    if (second) cap1 <= 4'h1;
    else cap0 <= 4'h1;
    @(posedge clk_i);
    cap0 <= 4'h0;
    cap1 <= 4'h0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic t_capture();
    logic [3:0] ens [3] = '{4'h4, 4'h8, 4'h0};
    logic       ea;
    ea = fa[0];
    for (int k = 0; k < 3; k++) begin
      wr(8'h00, {24'h0, 2'b11, ens[k], 2'b11});
      wb(1'b0, 8'h00, 32'h0000_0000, rd);
      check(rd, {24'h0, 2'b11, ens[k], 2'b11});
      pulse(1'b0);
      pulse(1'b1);
      ea = ea ^ ens[k][2] ^ ens[k][3];
      check({31'h0, fa[0]}, {31'h0, ea});
      wr(8'h04, 32'h0000_0004);
      wr(8'h04, 32'h0000_0008);
      ea = ea ^ ens[k][2] ^ ens[k][3];
      check({31'h0, fa[0]}, {31'h0, ea});
    end
    $display("capture test done");
  endtask

  // Interval run: period of five ticks, flop A toggles counted over ten periods
  task automatic t_match(input logic [3:0] en, input int expn);
    int   n;
    logic prev;
    wr(8'h04, 32'h0000_0000);
    wr(8'h84, 32'h0000_0002);
    wr(8'h00, {24'h0, 2'b11, en, 2'b11});
    wr(8'h08, 32'h0000_0002);
    wr(8'h0C, 32'h0000_0004);
    wr(8'h04, 32'h0000_0003);
    repeat (10) @(posedge clk_i);
    n = 0;
    prev = fa[0];
    repeat (50) begin
      @(posedge clk_i);
      if (fa[0] !== prev) n++;
      prev = fa[0];
    end
    check(32'(n), 32'(expn));
    check({31'h0, irq}, 32'h0000_0001);
    wr(8'h84, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    wr(8'h80, 32'h0000_00FF);
    // Let a full period pass so a fresh compare1 event must be latched
    repeat (6) @(posedge clk_i);
    wb(1'b0, 8'h80, 32'h0000_0000, rd);
    check(rd & 32'h0000_0002, 32'h0000_0002);
    wr(8'h04, 32'h0000_0000);
    wr(8'h80, 32'h0000_00FF);
    wr(8'h84, 32'h0000_0002);
    check({31'h0, irq}, 32'h0000_0000);
    $display("interval test done");
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_soft();
    t_capture();
    t_match(4'h0, 0);
    t_match(4'h1, 10);
    t_match(4'h2, 10);
    t_match(4'h3, 20);
    tally_and_finish();
  end
endmodule
